/* File: dual_uart_register_map.sv */
// Per-channel register bank of a dual asynchronous serial controller
`timescale 1ns/10ps
`default_nettype none
module dual_uart_register_map
  import dual_uart_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  // Clock, reset, enable
  input  wire logic            CLK_SYS,
  input  wire logic            RST,
  input  wire logic            CE,
  // Host register bus
  input  wire logic [2:0]      ADDR,
  input  wire logic            SEL_A_N,
  input  wire logic            SEL_B_N,
  input  wire logic            RD_N,
  input  wire logic            WR_N,
  input  wire logic [7:0]      WR_DATA,
  output logic      [7:0]      RD_DATA,
  // Receive and transmit data paths
  input  wire logic [1:0][7:0] RX_DATA,
  output logic      [1:0]      RX_POP,
  output logic      [1:0][7:0] TX_DATA,
  output logic      [1:0]      TX_PUSH,
  // Queue control pulses
  output logic      [1:0]      RXQ_CLEAR,
  output logic      [1:0]      TXQ_CLEAR,
  // Status from the channel logic
  input  wire logic [1:0][7:0] LINE_STATUS,
  input  wire logic [1:0][3:0] MODEM_LVL,
  input  wire logic [1:0][5:0] IRQ_CODE,
  input  wire logic [1:0]      TXQ_RDY,
  input  wire logic [1:0]      RXQ_RDY,
  // Configuration to the channel logic
  output logic      [1:0][7:0] CFG_DIV_LO,
  output logic      [1:0][7:0] CFG_DIV_HI,
  output logic      [1:0][7:0] CFG_DIV_FRAC,
  output logic      [1:0][7:0] CFG_IRQ_MASK,
  output logic      [1:0][7:0] CFG_QUEUE,
  output logic      [1:0][7:0] CFG_LINE,
  output logic      [1:0][7:0] CFG_MODEM,
  output logic      [1:0][7:0] CFG_ENH,
  output logic      [1:0][7:0] CFG_HALT,
  output logic      [1:0][7:0] CFG_TRIG,
  output logic      [1:0][7:0] CFG_FLOW_ON1,
  output logic      [1:0][7:0] CFG_FLOW_ON2,
  output logic      [1:0][7:0] CFG_FLOW_OFF1,
  output logic      [1:0][7:0] CFG_FLOW_OFF2
);
  if (CHANNELS != 2) begin : g_chk
    $error("dual_uart_register_map serves exactly two channels");
  end

  typedef struct packed {
    logic [1:0][7:0] div_lo, div_hi, div_frac, mask, queue, enh;
    logic [1:0][7:0] line, modem, scr, halt, trig;
    logic [1:0][7:0] flow_on_char_1, flow_on_char_2, flow_off_char_1, flow_off_char_2, tx_data;
    logic [1:0]      rx_pop, tx_push, rxq_clr, txq_clr;
    logic [7:0]      rd_data;
  } state_s;

  state_s q;
  state_s d;

  logic       rd_pulse;
  logic       wr_pulse;
  logic [1:0] rd_hit;
  logic [1:0] wr_hit;
  logic [1:0] msr_clr;
  logic [1:0][3:0] delta;
  reg_sel_e   sel_r [2];
  reg_sel_e   sel_w [2];

  bus_strobe_edge u_rd_edge (
    .CLK_SYS  (CLK_SYS),
    .RST      (RST),
    .CE       (CE),
    .strobe_n (RD_N),
    .pulse    (rd_pulse)
  );

  bus_strobe_edge u_wr_edge (
    .CLK_SYS  (CLK_SYS),
    .RST      (RST),
    .CE       (CE),
    .strobe_n (WR_N),
    .pulse    (wr_pulse)
  );

  // per-channel select
  // A read with both selects low answers from channel A only
  assign rd_hit[0] = rd_pulse && !SEL_A_N;
  assign rd_hit[1] = rd_pulse && !SEL_B_N && SEL_A_N;
  assign wr_hit[0] = wr_pulse && !SEL_A_N;
  assign wr_hit[1] = wr_pulse && !SEL_B_N;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      sel_r[c] = decode_sel(ADDR, q.line[c], q.enh[c][EF_EXT_BIT],
                            q.modem[c][MC_ALT_BIT],
                            q.modem[c][MC_RDY_BIT], 1'b1);
      sel_w[c] = decode_sel(ADDR, q.line[c], q.enh[c][EF_EXT_BIT],
                            q.modem[c][MC_ALT_BIT],
                            q.modem[c][MC_RDY_BIT], 1'b0);
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign msr_clr[g] = rd_hit[g] && (sel_r[g] == SEL_MSTAT);

    modem_delta_track #(
      .LINES (4)
    ) u_delta (
      .CLK_SYS (CLK_SYS),
      .RST     (RST),
      .CE      (CE),
      .lvl     (MODEM_LVL[g]),
      .clr     (msr_clr[g]),
      .delta   (delta[g])
    );
  end

  always_comb begin
    logic ext;
    ext = 1'b0;
    d = q;
    d.rx_pop = '0;
    d.tx_push = '0;
    d.rxq_clr = '0;
    d.txq_clr = '0;
    for (int c = 0; c < 2; c++) begin
      ext = q.enh[c][EF_EXT_BIT];
      if (wr_hit[c]) begin
        case (sel_w[c])
          SEL_HOLD: begin
            d.tx_data[c] = WR_DATA;
            d.tx_push[c] = 1'b1;
          end
          SEL_DIVLO: d.div_lo[c] = WR_DATA;
          SEL_DIVHI: d.div_hi[c] = WR_DATA;
          SEL_FRAC:  d.div_frac[c] = WR_DATA;
          SEL_MASK: begin
            d.mask[c] = merge_ext(q.mask[c], WR_DATA, EXT_IRQ_MASK, ext);
          end
          SEL_QUEUE: begin
            d.queue[c] = merge_ext(q.queue[c], WR_DATA & ~QC_SELF_CLR,
                                   EXT_QUEUE, ext);
            d.rxq_clr[c] = WR_DATA[QC_RXCLR_BIT];
            d.txq_clr[c] = WR_DATA[QC_TXCLR_BIT];
          end
          SEL_ENH:   d.enh[c] = WR_DATA;
          SEL_LINE:  d.line[c] = WR_DATA;
          SEL_MODEM: begin
            d.modem[c] = merge_ext(q.modem[c], WR_DATA, EXT_MODEM, ext);
          end
          SEL_SCR:   d.scr[c] = WR_DATA;
          SEL_HALT:  d.halt[c] = WR_DATA;
          SEL_TRIG:  d.trig[c] = WR_DATA;
          SEL_FLOW_ON_CHAR_1:  d.flow_on_char_1[c] = WR_DATA;
          SEL_FLOW_ON_CHAR_2:  d.flow_on_char_2[c] = WR_DATA;
          SEL_FLOW_OFF_CHAR_1: d.flow_off_char_1[c] = WR_DATA;
          SEL_FLOW_OFF_CHAR_2: d.flow_off_char_2[c] = WR_DATA;
          default: begin
          end
        endcase
      end
      if (rd_hit[c]) begin
        case (sel_r[c])
          SEL_HOLD: begin
            d.rd_data = RX_DATA[c];
            d.rx_pop[c] = 1'b1;
          end
          SEL_DIVLO: d.rd_data = q.div_lo[c];
          SEL_DIVHI: d.rd_data = q.div_hi[c];
          SEL_FRAC:  d.rd_data = q.div_frac[c];
          SEL_MASK: begin
            d.rd_data = gate_ext(q.mask[c], EXT_IRQ_MASK, ext);
          end
          SEL_QUEUE: begin
            d.rd_data = gate_ext({{2{q.queue[c][QC_EN_BIT]}}, IRQ_CODE[c]},
                                 EXT_SOURCE, ext);
          end
          SEL_ENH:   d.rd_data = q.enh[c];
          SEL_LINE:  d.rd_data = q.line[c];
          SEL_MODEM: begin
            d.rd_data = gate_ext(q.modem[c], EXT_MODEM, ext);
          end
          SEL_LSTAT: d.rd_data = LINE_STATUS[c];
          SEL_MSTAT: d.rd_data = {MODEM_LVL[c], delta[c]};
          SEL_SCR:   d.rd_data = q.scr[c];
          SEL_HALT:  d.rd_data = q.halt[c];
          SEL_TRIG:  d.rd_data = q.trig[c];
          SEL_RDY: begin
            d.rd_data = {2'b00, RXQ_RDY, 2'b00, TXQ_RDY};
          end
          SEL_FLOW_ON_CHAR_1:  d.rd_data = q.flow_on_char_1[c];
          SEL_FLOW_ON_CHAR_2:  d.rd_data = q.flow_on_char_2[c];
          SEL_FLOW_OFF_CHAR_1: d.rd_data = q.flow_off_char_1[c];
          SEL_FLOW_OFF_CHAR_2: d.rd_data = q.flow_off_char_2[c];
          default:   d.rd_data = REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      q <= '0;
    end else if (CE) begin
      q <= d;
    end
  end

  assign RD_DATA   = q.rd_data;
  assign RX_POP    = q.rx_pop;
  assign TX_PUSH   = q.tx_push;
  assign TX_DATA   = q.tx_data;
  assign RXQ_CLEAR = q.rxq_clr;
  assign TXQ_CLEAR = q.txq_clr;
  assign CFG_DIV_LO    = q.div_lo;
  assign CFG_DIV_HI    = q.div_hi;
  assign CFG_LINE      = q.line;
  assign CFG_ENH       = q.enh;
  assign CFG_HALT      = q.halt;
  assign CFG_TRIG      = q.trig;
  assign CFG_FLOW_ON1  = q.flow_on_char_1;
  assign CFG_FLOW_ON2  = q.flow_on_char_2;
  assign CFG_FLOW_OFF1 = q.flow_off_char_1;
  assign CFG_FLOW_OFF2 = q.flow_off_char_2;

  // stored extended bits lose effect when disabled
  for (genvar g = 0; g < 2; g++) begin : g_cfg
    assign CFG_IRQ_MASK[g] = gate_ext(q.mask[g], EXT_IRQ_MASK,
                                      q.enh[g][EF_EXT_BIT]);
    assign CFG_QUEUE[g] = gate_ext(q.queue[g], EXT_QUEUE,
                                   q.enh[g][EF_EXT_BIT]);
    assign CFG_MODEM[g] = gate_ext(q.modem[g], EXT_MODEM,
                                   q.enh[g][EF_EXT_BIT]);
    assign CFG_DIV_FRAC[g] = q.enh[g][EF_EXT_BIT] ? q.div_frac[g]
                                                   : REG_RESET;
  end

  sequence s_hold_read;
    rd_hit[0] && sel_r[0] == SEL_HOLD;
  endsequence

  sequence s_popped;
    RX_POP[0] && RD_DATA == $past(RX_DATA[0]);
  endsequence

  property p_hold_read;
    @(posedge CLK_SYS) disable iff (RST)
    s_hold_read |=> s_popped;
  endproperty
  a_hold_read: assert property (p_hold_read)
    else $error("holding read did not return and pop the byte");

  property p_div_write;
    @(posedge CLK_SYS) disable iff (RST)
    wr_hit[0] && ADDR == OFS_MASK && q.line[0][LF_DIV_BIT]
      |=> q.div_hi[0] == $past(WR_DATA) && $stable(q.mask[0]);
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("divisor high write went astray");

  property p_key_flow;
    @(posedge CLK_SYS) disable iff (RST)
    wr_hit[0] && ADDR == OFS_MODEM && q.line[0] == ENH_KEY
      |=> q.flow_on_char_1[0] == $past(WR_DATA) && $stable(q.modem[0]);
  endproperty
  a_key_flow: assert property (p_key_flow)
    else $error("flow character write went astray");

  property p_mask_gate;
    @(posedge CLK_SYS) disable iff (RST)
    wr_hit[0] && sel_w[0] == SEL_MASK && !q.enh[0][EF_EXT_BIT]
      |=> q.mask[0][7:4] == $past(q.mask[0][7:4]);
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("extended mask bits changed while disabled");

  property p_source_read;
    @(posedge CLK_SYS) disable iff (RST)
    rd_hit[0] && sel_r[0] == SEL_QUEUE
      |=> RD_DATA[7:6] == {2{q.queue[0][QC_EN_BIT]}};
  endproperty
  a_source_read: assert property (p_source_read)
    else $error("queue enable flags wrong in source read");

  property p_queue_reset;
    @(posedge CLK_SYS) disable iff (RST)
    wr_hit[0] && sel_w[0] == SEL_QUEUE && WR_DATA[QC_RXCLR_BIT]
      |=> RXQ_CLEAR[0] && !q.queue[0][QC_RXCLR_BIT];
  endproperty
  a_queue_reset: assert property (p_queue_reset)
    else $error("receive queue reset not pulsed");

  property p_scratch;
    @(posedge CLK_SYS) disable iff (RST)
    wr_hit[0] && sel_w[0] == SEL_SCR
      |=> q.scr[0] == $past(WR_DATA) && !TX_PUSH[0];
  endproperty
  a_scratch: assert property (p_scratch)
    else $error("scratch byte not stored");

  property p_ready_read;
    @(posedge CLK_SYS) disable iff (RST)
    rd_hit[0] && sel_r[0] == SEL_RDY
      |=> RD_DATA[7:6] == 2'b00 && RD_DATA[3:2] == 2'b00
          && RD_DATA[1:0] == $past(TXQ_RDY);
  endproperty
  a_ready_read: assert property (p_ready_read)
    else $error("ready flags read wrong");

  property p_ro_write;
    @(posedge CLK_SYS) disable iff (RST)
    wr_hit[0] && sel_w[0] == SEL_LSTAT |=> $stable(q.line[0])
      && $stable(q.modem[0]) && $stable(q.scr[0]);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to read-only status changed state");

endmodule // dual_uart_register_map
`default_nettype wire

/* File: dual_uart_pkg.sv */
// Shared constants, access decode and field helpers for the dual UART bank
`default_nettype none
package dual_uart_pkg;

  // Register addresses on the three address lines
  localparam logic [2:0] OFS_HOLD  = 3'h0;
  localparam logic [2:0] OFS_MASK  = 3'h1;
  localparam logic [2:0] OFS_QUEUE = 3'h2;
  localparam logic [2:0] OFS_LINE  = 3'h3;
  localparam logic [2:0] OFS_MODEM = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCR   = 3'h7;

  // Line-format value that opens the enhanced set
  localparam logic [7:0] ENH_KEY   = 8'hbf;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic       STROBE_IDLE = 1'b1;

  // Field positions
  localparam int LF_DIV_BIT   = 7;
  localparam int EF_EXT_BIT   = 4;
  localparam int MC_ALT_BIT   = 6;
  localparam int MC_RDY_BIT   = 2;
  localparam int QC_EN_BIT    = 0;
  localparam int QC_RXCLR_BIT = 1;
  localparam int QC_TXCLR_BIT = 2;

  // Bits that only exist while the extended fields are enabled, and the self-clearing queue bits
  localparam logic [7:0] EXT_IRQ_MASK = 8'hf0;
  localparam logic [7:0] EXT_QUEUE    = 8'h30;
  localparam logic [7:0] EXT_MODEM    = 8'he0;
  localparam logic [7:0] EXT_SOURCE   = 8'h30;
  localparam logic [7:0] QC_SELF_CLR  = 8'h06;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_HOLD, SEL_DIVLO, SEL_DIVHI, SEL_FRAC, SEL_MASK,
    SEL_QUEUE, SEL_ENH, SEL_LINE, SEL_MODEM, SEL_LSTAT, SEL_MSTAT,
    SEL_SCR, SEL_HALT, SEL_TRIG, SEL_RDY, SEL_FLOW_ON_CHAR_1, SEL_FLOW_ON_CHAR_2,
    SEL_FLOW_OFF_CHAR_1, SEL_FLOW_OFF_CHAR_2
  } reg_sel_e;

  function automatic reg_sel_e decode_sel(
    input logic [2:0] addr,
    input logic [7:0] lf,
    input logic       ext,
    input logic       alt,
    input logic       rdy,
    input logic       rd);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (lf == ENH_KEY) begin
      if (addr == OFS_HOLD) sel = SEL_DIVLO;
      else if (addr == OFS_MASK) sel = SEL_DIVHI;
      else if (addr == OFS_QUEUE) sel = SEL_ENH;
      else if (addr == OFS_LINE) sel = SEL_LINE;
      else if (addr == OFS_MODEM) sel = SEL_FLOW_ON_CHAR_1;
      else if (addr == OFS_LSTAT) sel = SEL_FLOW_ON_CHAR_2;
      else if (addr == OFS_MSTAT) sel = SEL_FLOW_OFF_CHAR_1;
      else sel = SEL_FLOW_OFF_CHAR_2;
    end else if (addr == OFS_HOLD) begin
      sel = lf[LF_DIV_BIT] ? SEL_DIVLO : SEL_HOLD;
    end else if (addr == OFS_MASK) begin
      sel = lf[LF_DIV_BIT] ? SEL_DIVHI : SEL_MASK;
    end else if (addr == OFS_QUEUE) begin
      if (!lf[LF_DIV_BIT]) sel = SEL_QUEUE;
      else if (ext) sel = SEL_FRAC;
    end else if (addr == OFS_LINE) begin
      sel = SEL_LINE;
    end else if (addr == OFS_MODEM) begin
      sel = SEL_MODEM;
    end else if (addr == OFS_LSTAT) begin
      sel = SEL_LSTAT;
    end else if (addr == OFS_MSTAT) begin
      sel = (alt && ext) ? SEL_HALT : SEL_MSTAT;
    end else if (alt && ext) begin
      sel = SEL_TRIG;
    end else begin
      sel = (rd && rdy) ? SEL_RDY : SEL_SCR;
    end
    return sel;
  endfunction

  // Hidden extended bits read as zero
  function automatic logic [7:0] gate_ext(
    input logic [7:0] v, input logic [7:0] m, input logic ext);
    return ext ? v : (v & ~m);
  endfunction

  // Extended bits keep their value unless enabled
  function automatic logic [7:0] merge_ext(
    input logic [7:0] old, input logic [7:0] nv,
    input logic [7:0] m, input logic ext);
    return ext ? nv : ((old & m) | (nv & ~m));
  endfunction

endpackage
`default_nettype wire

/* File: bus_strobe_edge.sv */
// Turns an active-low bus strobe into a one-cycle pulse at its start
`timescale 1ns/10ps
`default_nettype none
module bus_strobe_edge
  import dual_uart_pkg::*;
(
  // Clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic CE,
  // Strobe in, pulse out
  input  wire logic strobe_n,
  output logic      pulse
);
  typedef struct packed {
    logic prev_n;
  } state_s;

  state_s q;
  state_s d;

  always_comb begin
    d = q;
    d.prev_n = strobe_n;
  end

  // Only the falling edge counts, a held strobe acts once
  assign pulse = CE && q.prev_n && !strobe_n;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      q.prev_n <= STROBE_IDLE;
    end else if (CE) begin
      q <= d;
    end
  end
endmodule // bus_strobe_edge
`default_nettype wire

/* File: modem_delta_track.sv */
// Change flags for the modem inputs, cleared by a status read
`timescale 1ns/10ps
`default_nettype none
module modem_delta_track
  import dual_uart_pkg::*;
#(
  parameter int LINES = 4
) (
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  input  wire logic             CE,
  // Levels and clear
  input  wire logic [LINES-1:0] lvl,
  input  wire logic             clr,
  output logic      [LINES-1:0] delta
);
  if (LINES != 4) begin : g_chk
    $error("modem_delta_track serves exactly four inputs");
  end

  typedef struct packed {
    logic [LINES-1:0] prev;
    logic [LINES-1:0] delta;
    logic             primed;
  } state_s;

  state_s q;
  state_s d;

  // Change seen in the clearing cycle survives the clear
  always_comb begin
    d = q;
    d.prev = lvl;
    d.primed = 1'b1;
    d.delta = (clr ? '0 : q.delta) | ((lvl ^ q.prev) & {LINES{q.primed}});
  end

  assign delta = q.delta;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      q <= '0;
    end else if (CE) begin
      q <= d;
    end
  end
endmodule // modem_delta_track
`default_nettype wire

/* File: host_bus_model.sv */
// Host processor model driving the register bus of both channels
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  // Clock
  input  wire logic       CLK_SYS,
  // Register bus
  output logic      [2:0] ADDR,
  output logic            SEL_A_N,
  output logic            SEL_B_N,
  output logic            RD_N,
  output logic            WR_N,
  output logic      [7:0] WR_DATA,
  input  wire logic [7:0] RD_DATA
);
  initial begin
    ADDR = 3'h0;
    SEL_A_N = 1'b1;
    SEL_B_N = 1'b1;
    RD_N = 1'b1;
    WR_N = 1'b1;
    WR_DATA = 8'h00;
  end

  task automatic access(input logic [1:0] sel_n, input logic [2:0] a,
                        input logic wr, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge CLK_SYS);
    ADDR = a;
    {SEL_B_N, SEL_A_N} = sel_n;
    WR_DATA = d;
    if (wr) begin
      WR_N = 1'b0;
    end else begin
      RD_N = 1'b0;
    end
    @(negedge CLK_SYS);
    q = RD_DATA;
    WR_N = 1'b1;
    RD_N = 1'b1;
    {SEL_B_N, SEL_A_N} = 2'b11;
    // Released lines must not keep showing the last value
    WR_DATA = ~d;
    ADDR = ~a;
  endtask
endmodule // host_bus_model
`default_nettype wire

/* File: dual_uart_register_map_tb_top.sv */
// Self-checking bench for the dual UART register bank
`timescale 1ns/10ps
`default_nettype none
module dual_uart_register_map_tb_top
  import dual_uart_pkg::*;
;
  localparam logic [1:0] CH_A = 2'b10;
  localparam logic [1:0] CH_B = 2'b01;
  localparam int MAX_CYC = 2000;

  typedef struct packed {
    logic [7:0] lf;
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] exp;
  } row_s;

  localparam row_s ROWS [0:11] = '{
    '{8'h80, 3'h0, 8'h5a, 8'h5a}, '{8'h80, 3'h1, 8'ha5, 8'ha5},
    '{8'h80, 3'h2, 8'hc3, 8'hc3}, '{8'h00, 3'h1, 8'hff, 8'hff},
    '{8'h00, 3'h3, 8'h1b, 8'h1b}, '{8'h00, 3'h4, 8'ha3, 8'ha3},
    '{8'h00, 3'h7, 8'h77, 8'h77}, '{8'hbf, 3'h4, 8'h11, 8'h11},
    '{8'hbf, 3'h5, 8'h13, 8'h13}, '{8'hbf, 3'h6, 8'h91, 8'h91},
    '{8'hbf, 3'h7, 8'h93, 8'h93}, '{8'hbf, 3'h2, 8'hdf, 8'hdf}};

  logic            CLK_SYS;
  logic            RST;
  logic            CE;
  logic [2:0]      ADDR;
  logic            SEL_A_N;
  logic            SEL_B_N;
  logic            RD_N;
  logic            WR_N;
  logic [7:0]      WR_DATA;
  logic [7:0]      RD_DATA;
  logic [1:0][7:0] RX_DATA;
  logic [1:0]      RX_POP;
  logic [1:0][7:0] TX_DATA;
  logic [1:0]      TX_PUSH;
  logic [1:0]      RXQ_CLEAR;
  logic [1:0]      TXQ_CLEAR;
  logic [1:0][7:0] LINE_STATUS;
  logic [1:0][3:0] MODEM_LVL;
  logic [1:0][5:0] IRQ_CODE;
  logic [1:0]      TXQ_RDY;
  logic [1:0]      RXQ_RDY;
  logic [1:0][7:0] CFG_DIV_LO;
  logic [1:0][7:0] CFG_IRQ_MASK;
  logic [1:0][7:0] CFG_QUEUE;
  logic [1:0][7:0] CFG_HALT;
  logic [1:0][7:0] CFG_DIV_HI;
  logic [1:0][7:0] CFG_DIV_FRAC;
  logic [1:0][7:0] CFG_LINE;
  logic [1:0][7:0] CFG_MODEM;
  logic [1:0][7:0] CFG_ENH;
  logic [1:0][7:0] CFG_TRIG;
  logic [1:0][7:0] CFG_FLOW_ON1;
  logic [1:0][7:0] CFG_FLOW_ON2;
  logic [1:0][7:0] CFG_FLOW_OFF1;
  logic [1:0][7:0] CFG_FLOW_OFF2;
  logic [7:0]      rq;
  int              err_total = 0;
  int              compares = 0;
  int              cycles = 0;

  dual_uart_register_map i_dual_uart_register_map (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
    .ADDR(ADDR), .SEL_A_N(SEL_A_N), .SEL_B_N(SEL_B_N),
    .RD_N(RD_N), .WR_N(WR_N), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
    .RX_DATA(RX_DATA), .RX_POP(RX_POP), .TX_DATA(TX_DATA),
    .TX_PUSH(TX_PUSH), .RXQ_CLEAR(RXQ_CLEAR), .TXQ_CLEAR(TXQ_CLEAR),
    .LINE_STATUS(LINE_STATUS), .MODEM_LVL(MODEM_LVL),
    .IRQ_CODE(IRQ_CODE), .TXQ_RDY(TXQ_RDY), .RXQ_RDY(RXQ_RDY),
    .CFG_DIV_LO(CFG_DIV_LO), .CFG_DIV_HI(CFG_DIV_HI),
    .CFG_DIV_FRAC(CFG_DIV_FRAC), .CFG_IRQ_MASK(CFG_IRQ_MASK),
    .CFG_QUEUE(CFG_QUEUE), .CFG_LINE(CFG_LINE), .CFG_MODEM(CFG_MODEM),
    .CFG_ENH(CFG_ENH), .CFG_HALT(CFG_HALT), .CFG_TRIG(CFG_TRIG),
    .CFG_FLOW_ON1(CFG_FLOW_ON1), .CFG_FLOW_ON2(CFG_FLOW_ON2),
    .CFG_FLOW_OFF1(CFG_FLOW_OFF1), .CFG_FLOW_OFF2(CFG_FLOW_OFF2)
  );

  host_bus_model i_host_bus_model (
    .CLK_SYS(CLK_SYS), .ADDR(ADDR), .SEL_A_N(SEL_A_N),
    .SEL_B_N(SEL_B_N), .RD_N(RD_N), .WR_N(WR_N),
    .WR_DATA(WR_DATA), .RD_DATA(RD_DATA)
  );

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  task automatic end_sim;
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYC) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [2:0] a,
                    input logic [7:0] d);
    i_host_bus_model.access(s, a, 1'b1, d, rq);
  endtask

  task automatic rd(input logic [1:0] s, input logic [2:0] a);
    i_host_bus_model.access(s, a, 1'b0, 8'h00, rq);
  endtask

  initial begin
    RST = 1'b1;
    CE = 1'b1;
    RX_DATA = '0;
    LINE_STATUS = '0;
    MODEM_LVL = '0;
    IRQ_CODE = '0;
    TXQ_RDY = 2'b00;
    RXQ_RDY = 2'b00;
    repeat (16) @(negedge CLK_SYS);
    RST = 1'b0;
    chk("reset rd_data", RD_DATA, 8'h00);
    chk("reset div_lo", CFG_DIV_LO[0], 8'h00);
    // Key value, then extended fields on
    wr(CH_A, 3'h3, 8'hbf);
    wr(CH_A, 3'h2, 8'h10);
    foreach (ROWS[i]) begin
      wr(CH_A, 3'h3, ROWS[i].lf);
      wr(CH_A, ROWS[i].a, ROWS[i].d);
      rd(CH_A, ROWS[i].a);
      chk("table read", rq, ROWS[i].exp);
    end
    chk("div_lo cfg", CFG_DIV_LO[0], 8'h5a);
    chk("div_hi cfg", CFG_DIV_HI[0], 8'ha5);
    chk("frac cfg", CFG_DIV_FRAC[0], 8'hc3);
    chk("line cfg", CFG_LINE[0], 8'hbf);
    chk("modem cfg", CFG_MODEM[0], 8'ha3);
    chk("enh cfg", CFG_ENH[0], 8'hdf);
    chk("flow on1 cfg", CFG_FLOW_ON1[0], 8'h11);
    chk("flow on2 cfg", CFG_FLOW_ON2[0], 8'h13);
    chk("flow off1 cfg", CFG_FLOW_OFF1[0], 8'h91);
    chk("flow off2 cfg", CFG_FLOW_OFF2[0], 8'h93);
    // Holding registers, back to normal set
    wr(CH_A, 3'h3, 8'h00);
    RX_DATA[0] = 8'h3c;
    rd(CH_A, 3'h0);
    chk("rx byte", rq, 8'h3c);
    chk("rx pop", 8'(RX_POP), 8'h01);
    wr(CH_A, 3'h0, 8'h81);
    chk("tx push", 8'(TX_PUSH), 8'h01);
    chk("tx byte", TX_DATA[0], 8'h81);
    // Queue control write and status read
    wr(CH_A, 3'h2, 8'hf7);
    chk("rx clear", 8'(RXQ_CLEAR), 8'h01);
    chk("tx clear", 8'(TXQ_CLEAR), 8'h01);
    chk("queue cfg", CFG_QUEUE[0], 8'hf1);
    IRQ_CODE[0] = 6'h3c;
    rd(CH_A, 3'h2);
    chk("irq source", rq, 8'hfc);
    // Extended fields off: hidden bits read zero
    wr(CH_A, 3'h3, 8'hbf);
    wr(CH_A, 3'h2, 8'h0f);
    wr(CH_A, 3'h3, 8'h00);
    rd(CH_A, 3'h2);
    chk("src hidden", rq, 8'hcc);
    rd(CH_A, 3'h1);
    chk("mask hidden", rq, 8'h0f);
    chk("mask cfg", CFG_IRQ_MASK[0], 8'h0f);
    chk("queue hidden", CFG_QUEUE[0], 8'hc1);
    chk("frac hidden", CFG_DIV_FRAC[0], 8'h00);
    chk("modem hidden", CFG_MODEM[0], 8'h03);
    wr(CH_A, 3'h1, 8'h00);
    wr(CH_A, 3'h3, 8'h80);
    rd(CH_A, 3'h2);
    chk("frac closed", rq, 8'h00);
    // Read-only status
    LINE_STATUS[0] = 8'h96;
    wr(CH_A, 3'h5, 8'h00);
    rd(CH_A, 3'h5);
    chk("line status", rq, 8'h96);
    MODEM_LVL[0] = 4'h9;
    repeat (2) @(negedge CLK_SYS);
    rd(CH_A, 3'h6);
    chk("modem delta", rq, 8'h99);
    rd(CH_A, 3'h6);
    chk("modem clear", rq, 8'h90);
    // Alternate registers and ready flags
    wr(CH_A, 3'h3, 8'hbf);
    wr(CH_A, 3'h2, 8'h10);
    wr(CH_A, 3'h3, 8'h00);
    rd(CH_A, 3'h1);
    chk("mask kept", rq, 8'hf0);
    wr(CH_A, 3'h4, 8'h40);
    wr(CH_A, 3'h6, 8'h5c);
    chk("halt cfg", CFG_HALT[0], 8'h5c);
    rd(CH_A, 3'h6);
    chk("halt read", rq, 8'h5c);
    wr(CH_A, 3'h7, 8'h3e);
    rd(CH_A, 3'h7);
    chk("trigger", rq, 8'h3e);
    chk("trigger cfg", CFG_TRIG[0], 8'h3e);
    wr(CH_A, 3'h4, 8'h04);
    TXQ_RDY = 2'b01;
    RXQ_RDY = 2'b10;
    rd(CH_A, 3'h7);
    chk("ready flags", rq, 8'h21);
    // Channel B stands apart from A
    wr(CH_B, 3'h7, 8'h42);
    rd(CH_B, 3'h7);
    chk("scratch b", rq, 8'h42);
    wr(CH_A, 3'h4, 8'h00);
    rd(CH_A, 3'h7);
    chk("scratch a", rq, 8'h77);
    // Channel B holding registers
    RX_DATA[1] = 8'h6e;
    rd(CH_B, 3'h0);
    chk("rx byte b", rq, 8'h6e);
    chk("rx pop b", 8'(RX_POP), 8'h02);
    wr(CH_B, 3'h0, 8'hc5);
    chk("tx push b", 8'(TX_PUSH), 8'h02);
    chk("tx byte b", TX_DATA[1], 8'hc5);
    // Both selects low write both channels
    wr(2'b00, 3'h7, 8'h5d);
    rd(CH_A, 3'h7);
    chk("both sel a", rq, 8'h5d);
    rd(CH_B, 3'h7);
    chk("both sel b", rq, 8'h5d);
    // Strobe seen only while disabled is lost
    CE = 1'b0;
    wr(CH_A, 3'h7, 8'h11);
    CE = 1'b1;
    rd(CH_A, 3'h7);
    chk("ce freeze", rq, 8'h5d);
    // Reset in mid-run clears the set
    RST = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    RST = 1'b0;
    chk("rerun div_hi", CFG_DIV_HI[0], 8'h00);
    rd(CH_A, 3'h7);
    chk("rerun scratch", rq, 8'h00);
    end_sim();
  end
endmodule // dual_uart_register_map_tb_top
`default_nettype wire
